// file: inc/vac_pkg.sv
/*
 * constants shared by the vco autocalibration block: register offsets,
 * field positions, reset values and timing figures.
 * assumes a plain register port with byte-wide offsets and a 20 MHz sys_clk.
 */
package vac_pkg;
    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [4:0] OFS_INT = 5'h03;
    localparam logic [4:0] OFS_FRAC = 5'h04;
    localparam logic [4:0] OFS_VCO = 5'h05;
    localparam logic [4:0] OFS_CAL_CFG = 5'h0A;
    localparam logic [4:0] OFS_SW_READ = 5'h10;
    localparam logic [4:0] OFS_STATUS = 5'h11;

    // ----------------------------------------------------------------
    // field layout of the calibration configuration and vco registers, and word widths
    // ----------------------------------------------------------------
    localparam int NSEL_LSB = 0;
    localparam int KSEL_LSB = 6;
    localparam int CAL_DIS_BIT = 11;
    localparam int MSEL_LSB = 13;
    localparam int SW_LSB = 7;
    localparam int INT_W = 19;
    localparam int FRAC_W = 24;
    localparam int CNT_W = 28;

    // ----------------------------------------------------------------
    // reset values and figures
    // ----------------------------------------------------------------
    localparam logic [23:0] CAL_CFG_RST = 24'h00_2045;
    localparam logic [23:0] INT_RST = 24'h00_0014;
    localparam logic [23:0] VCO_RST = 24'h00_0000;
    localparam logic [7:0] SW_FIRST_TRIAL = 8'h80;
    localparam int WAIT_UNIT = 128;
    localparam int SEARCH_STEPS = 8;
    localparam logic [4:0] CAL_XFER_CLKS = 5'd20;
    localparam logic [4:0] MAN_XFER_CLKS = 5'd16;
    localparam int SYS_CLK_HZ = 20_000_000;
    localparam int FSM_CLK_MAX_HZ = 50_000_000;

    typedef enum logic [2:0] {
        VAC_IDLE = 3'b000,
        VAC_PRESET = 3'b001,
        VAC_WAIT = 3'b010,
        VAC_SYNC = 3'b011,
        VAC_MEAS = 3'b100,
        VAC_SEND = 3'b101,
        VAC_DONE = 3'b110
    } vac_state_e;
endpackage

// file: rtl/vac_fsm_clk_div.sv
/*
 * divider that turns sys_clk into the one-cycle fsm clock enable.
 * assumes sys_clk is the reference and mSel is stable between calibrations.
 */
module vac_fsm_clk_div (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic [1:0] mSel,
    output logic fsmTick
);
    logic [4:0] divCnt_q;
    logic [4:0] divMask;
    logic fsmTick_q;

    // ----------------------------------------------------------------
    // period is the reference period times 2^m, m = 0, 2, 4 or 5
    // ----------------------------------------------------------------
    assign divMask = (mSel == 2'd0) ? 5'h00 : (mSel == 2'd1) ? 5'h03 :
                     (mSel == 2'd2) ? 5'h0F : 5'h1F;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            divCnt_q <= 5'h00;
            fsmTick_q <= 1'b0;
        end else begin
            divCnt_q <= ((divCnt_q & divMask) == divMask) ? 5'h00 : divCnt_q + 5'h01;
            fsmTick_q <= ((divCnt_q & divMask) == divMask);
        end
    end

    assign fsmTick = fsmTick_q;
endmodule

// file: rtl/vac_vco_serial_port.sv
/*
 * vco_serial_port transmitter: shifts a word msb first, one bit per fsm tick.
 * assumes start is only raised while busy is low.
 */
module vac_vco_serial_port (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic fsmTick,
    input wire logic start,
    input wire logic [19:0] word,
    input wire logic [4:0] numClk,
    output logic busy,
    output logic vcoSerialClock,
    output logic vcoSerialData,
    output logic vcoSerialLatch
);
    logic [19:0] shift_q;
    logic [4:0] left_q;
    logic busy_q;
    logic clk_q;
    logic dat_q;
    logic latch_q;

    // shares the fsm enable with the calibration controller
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            shift_q <= 20'h0_0000;
            left_q <= 5'd0;
            busy_q <= 1'b0;
            clk_q <= 1'b0;
            dat_q <= 1'b0;
            latch_q <= 1'b0;
        end else begin
            clk_q <= 1'b0;
            latch_q <= 1'b0;
            if (start) begin
                shift_q <= word;
                left_q <= numClk;
                busy_q <= 1'b1;
            end else if (busy_q && fsmTick) begin
                if (left_q == 5'd0) begin
                    busy_q <= 1'b0;
                    latch_q <= 1'b1;
                end else begin
                    dat_q <= shift_q[19];
                    shift_q <= {shift_q[18:0], 1'b0};
                    clk_q <= 1'b1;
                    left_q <= left_q - 5'd1;
                end
            end
        end
    end

    assign busy = busy_q;
    assign vcoSerialClock = clk_q;
    assign vcoSerialData = dat_q;
    assign vcoSerialLatch = latch_q;
endmodule

// file: rtl/vac_autocal.sv
/*
 * vco autocalibration controller with its register port, binary switch
 * search, deferred frequency load and manual vco register forwarding.
 * assumes pdTick (one per phase detector cycle) and vcoTick (one per
 * counted vco cycle) are synchronous one-cycle pulses on sys_clk.
 */
// Overview of operation
// - fsm and vco serial port run from the reference, at most 50 MHz.
// - fsm period is the reference period times 2^m, m in 0,2,4,5.
// - expected count is floor of divide ratio times 2^n.
// - measurement code 0..7 maps to n of 0,1,2,3,5,6,7,8.
// - each measurement is preceded by a wait of k*128 fsm cycles.
// - wait, measure and 20-clock transfer repeat eight times: core then bands.
// - with calibration on, a fractional write starts it; load follows completion.
// - with calibration off, a fractional write loads the modulator at once.
// - the chosen eight-bit switch word is readable after every calibration.
// - manual switch and integer writes with calibration off act immediately.
// - with calibration off, vco register writes go out in 16 serial clocks.
// - the vco serial port uses the same fsm clock enable.
// - integer part comes from the integer register, fraction from fractional.
// - calibration bit is set during the search and cleared afterwards.
// - each measurement counts vco cycles over 2^n phase detector periods.
// - divide ratio is integer plus fraction over 2^24.
// - rewriting an unchanged frequency reruns calibration.
module vac_autocal #(
    parameter int INT_BITS = 19,
    parameter int FRAC_BITS = 24
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic [4:0] regAddr,
    input wire logic [23:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [23:0] regRdata,
    input wire logic pdTick,
    input wire logic vcoTick,
    output logic [INT_BITS-1:0] intLoad,
    output logic [FRAC_BITS-1:0] fracLoad,
    output logic freqLoadStrobe,
    output logic vcoCalBit,
    output logic calBusy,
    output logic [7:0] vcoSwitch,
    output logic vcoSerialClock,
    output logic vcoSerialData,
    output logic vcoSerialLatch
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [3:0] nFromCode(input logic [2:0] code);
        nFromCode = (code < 3'd4) ? {1'b0, code} : {1'b0, code} + 4'd1;
    endfunction

    function automatic logic [27:0] expectedCount(input logic [18:0] nInt,
                                                  input logic [23:0] nFrac,
                                                  input logic [3:0] n);
        logic [50:0] ratio;
        ratio = {8'h00, nInt, nFrac} << n;
        expectedCount = {1'b0, ratio[50:24]};
    endfunction

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic [23:0] calCfg_q;
    logic [18:0] intReg_q;
    logic [23:0] fracReg_q;
    logic [15:0] vcoReg_q;
    logic [7:0] swRead_q;
    logic [23:0] rdata_q;
    logic [18:0] intLoad_q;
    logic [23:0] fracLoad_q;
    logic load_q;
    logic calBit_q;
    logic [7:0] swTrial_q;
    logic [7:0] swTrial_d;
    logic [2:0] step_q;
    logic [8:0] waitCnt_q;
    logic [8:0] pdCnt_q;
    logic [27:0] vcoCnt_q;
    logic [27:0] expect_q;
    vac_pkg::vac_state_e state_q;
    vac_pkg::vac_state_e state_d;

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    logic wrInt;
    logic wrFrac;
    logic wrVco;
    logic wrCfg;
    logic calDisabled;
    logic [3:0] nExp;
    logic [8:0] waitLen;
    logic [8:0] pdLen;
    logic fsmTick;
    logic serBusy;
    logic serStart;
    logic [19:0] serWord;
    logic [4:0] serLen;
    logic manualSend;
    logic calSend;
    logic keepBit;
    logic [7:0] stepBit;

    assign wrInt = regWr && (regAddr == vac_pkg::OFS_INT);
    assign wrFrac = regWr && (regAddr == vac_pkg::OFS_FRAC);
    assign wrVco = regWr && (regAddr == vac_pkg::OFS_VCO);
    assign wrCfg = regWr && (regAddr == vac_pkg::OFS_CAL_CFG);
    assign calDisabled = calCfg_q[vac_pkg::CAL_DIS_BIT];
    assign nExp = nFromCode(calCfg_q[vac_pkg::NSEL_LSB +: 3]);
    assign waitLen = {calCfg_q[vac_pkg::KSEL_LSB +: 2], 7'h00};
    assign pdLen = 9'h001 << nExp;
    assign stepBit = 8'h80 >> step_q;
    assign keepBit = (vcoCnt_q < expect_q);

    // ----------------------------------------------------------------
    // fsm clock enable and serial transmitter
    // ----------------------------------------------------------------
    vac_fsm_clk_div u_div (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .mSel(calCfg_q[vac_pkg::MSEL_LSB +: 2]),
        .fsmTick(fsmTick)
    );

    assign manualSend = wrVco && calDisabled && !serBusy;
    assign calSend = (state_q == vac_pkg::VAC_PRESET || state_q == vac_pkg::VAC_SEND) &&
                     !serBusy && !manualSend;
    assign serStart = manualSend || calSend;
    // cal transfers patch the switch field and send 0 in place of stored bit 15; address and id stay as stored
    assign serWord = manualSend ? {regWdata[15:0], 4'h0} :
                     {1'b0, swTrial_q, vcoReg_q[vac_pkg::SW_LSB-1:0], 4'h0};
    assign serLen = manualSend ? vac_pkg::MAN_XFER_CLKS : vac_pkg::CAL_XFER_CLKS;

    vac_vco_serial_port u_ser (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .fsmTick(fsmTick),
        .start(serStart),
        .word(serWord),
        .numClk(serLen),
        .busy(serBusy),
        .vcoSerialClock(vcoSerialClock),
        .vcoSerialData(vcoSerialData),
        .vcoSerialLatch(vcoSerialLatch)
    );

    // ----------------------------------------------------------------
    // search state machine
    // ----------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        swTrial_d = swTrial_q;
        unique case (state_q)
            vac_pkg::VAC_IDLE: begin
            end
            vac_pkg::VAC_PRESET: begin
                if (calSend) begin
                    state_d = vac_pkg::VAC_WAIT;
                end
            end
            vac_pkg::VAC_WAIT: begin
                if (!serBusy && (waitCnt_q >= waitLen)) begin
                    state_d = vac_pkg::VAC_SYNC;
                end
            end
            vac_pkg::VAC_SYNC: begin
                if (pdTick) begin
                    state_d = vac_pkg::VAC_MEAS;
                end
            end
            vac_pkg::VAC_MEAS: begin
                if (pdTick && (pdCnt_q + 9'd1 >= pdLen)) begin
                    state_d = vac_pkg::VAC_SEND;
                    swTrial_d = keepBit ? swTrial_q : (swTrial_q & ~stepBit);
                    if (step_q != 3'd7) begin
                        swTrial_d = swTrial_d | (stepBit >> 1);
                    end
                end
            end
            vac_pkg::VAC_SEND: begin
                if (calSend) begin
                    state_d = (step_q == 3'd7) ? vac_pkg::VAC_DONE : vac_pkg::VAC_WAIT;
                end
            end
            vac_pkg::VAC_DONE: begin
                if (!serBusy) begin
                    state_d = vac_pkg::VAC_IDLE;
                end
            end
            default: begin
                state_d = vac_pkg::VAC_IDLE;
            end
        endcase
        if (wrFrac && !calDisabled) begin
            state_d = vac_pkg::VAC_PRESET;
            swTrial_d = vac_pkg::SW_FIRST_TRIAL;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= vac_pkg::VAC_IDLE;
            swTrial_q <= 8'h00;
        end else begin
            state_q <= state_d;
            swTrial_q <= swTrial_d;
        end
    end

    // step counter, wait and measurement counters
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            step_q <= 3'd0;
            waitCnt_q <= 9'd0;
            pdCnt_q <= 9'd0;
            vcoCnt_q <= 28'd0;
            expect_q <= 28'd0;
        end else begin
            if (state_d == vac_pkg::VAC_PRESET) begin
                step_q <= 3'd0;
            end else if (state_q == vac_pkg::VAC_SEND && calSend) begin
                step_q <= step_q + 3'd1;
            end
            if (state_q != vac_pkg::VAC_WAIT) begin
                waitCnt_q <= 9'd0;
            end else if (fsmTick && !serBusy) begin
                waitCnt_q <= waitCnt_q + 9'd1;
            end
            if (state_q == vac_pkg::VAC_SYNC) begin
                pdCnt_q <= 9'd0;
                vcoCnt_q <= 28'd0;
                expect_q <= expectedCount(intReg_q, fracReg_q, nExp);
            end else if (state_q == vac_pkg::VAC_MEAS) begin
                pdCnt_q <= pdTick ? pdCnt_q + 9'd1 : pdCnt_q;
                vcoCnt_q <= vcoTick ? vcoCnt_q + 28'd1 : vcoCnt_q;
            end
        end
    end

    // ----------------------------------------------------------------
    // register file, deferred load and readback
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            calCfg_q <= vac_pkg::CAL_CFG_RST;
            intReg_q <= vac_pkg::INT_RST[18:0];
            fracReg_q <= 24'h00_0000;
            vcoReg_q <= vac_pkg::VCO_RST[15:0];
        end else begin
            if (wrCfg) begin
                calCfg_q <= regWdata;
            end
            if (wrInt) begin
                intReg_q <= regWdata[18:0];
            end
            if (wrFrac) begin
                fracReg_q <= regWdata;
            end
            if (wrVco) begin
                vcoReg_q <= regWdata[15:0];
            end
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            intLoad_q <= vac_pkg::INT_RST[18:0];
            fracLoad_q <= 24'h00_0000;
            load_q <= 1'b0;
            calBit_q <= 1'b0;
            swRead_q <= 8'h00;
        end else begin
            load_q <= 1'b0;
            if (calDisabled && wrInt) begin
                intLoad_q <= regWdata[18:0];
                load_q <= 1'b1;
            end
            if (calDisabled && wrFrac) begin
                fracLoad_q <= regWdata;
                load_q <= 1'b1;
            end
            if (state_q == vac_pkg::VAC_DONE && state_d == vac_pkg::VAC_IDLE) begin
                intLoad_q <= intReg_q;
                fracLoad_q <= fracReg_q;
                load_q <= 1'b1;
                swRead_q <= swTrial_q;
            end else if (manualSend) begin
                swRead_q <= regWdata[vac_pkg::SW_LSB +: 8];
            end
            calBit_q <= (state_d != vac_pkg::VAC_IDLE);
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rdata_q <= 24'h00_0000;
        end else if (regRd) begin
            unique case (regAddr)
                vac_pkg::OFS_INT: rdata_q <= {5'h00, intReg_q};
                vac_pkg::OFS_FRAC: rdata_q <= fracReg_q;
                vac_pkg::OFS_VCO: rdata_q <= {8'h00, vcoReg_q};
                vac_pkg::OFS_CAL_CFG: rdata_q <= calCfg_q;
                vac_pkg::OFS_SW_READ: rdata_q <= {16'h0000, swRead_q};
                vac_pkg::OFS_STATUS: rdata_q <= {20'h0_0000, state_q != vac_pkg::VAC_IDLE,
                                                  state_q};
                default: rdata_q <= 24'h00_0000;
            endcase
        end else begin
            rdata_q <= 24'h00_0000;
        end
    end

    assign regRdata = rdata_q;
    assign intLoad = intLoad_q;
    assign fracLoad = fracLoad_q;
    assign freqLoadStrobe = load_q;
    assign vcoCalBit = calBit_q;
    assign calBusy = calBit_q;
    assign vcoSwitch = swRead_q;
endmodule

// file: tb/vac_autocal_asserts.sv
/*
 * port-level assertions for vac_autocal, bound into every instance.
 * assumes strobes are single cycles and never both high at once.
 */
module vac_autocal_asserts #(
    parameter int INT_BITS = 19,
    parameter int FRAC_BITS = 24
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic [4:0] regAddr,
    input wire logic [23:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [23:0] regRdata,
    input wire logic pdTick,
    input wire logic vcoTick,
    input wire logic [INT_BITS-1:0] intLoad,
    input wire logic [FRAC_BITS-1:0] fracLoad,
    input wire logic freqLoadStrobe,
    input wire logic vcoCalBit,
    input wire logic calBusy,
    input wire logic [7:0] vcoSwitch,
    input wire logic vcoSerialClock,
    input wire logic vcoSerialData,
    input wire logic vcoSerialLatch
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);

    // ----------------------------------------------------------------
    // shadow of the calibration disable bit and serial clock count
    // ----------------------------------------------------------------
    logic calDis_q;
    logic [4:0] clkCnt_q;
    logic wrFrac;
    logic wrVco;
    assign wrFrac = regWr && regAddr == vac_pkg::OFS_FRAC;
    assign wrVco = regWr && regAddr == vac_pkg::OFS_VCO;
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            calDis_q <= 1'b0;
            clkCnt_q <= 5'h0;
        end else begin
            if (regWr && regAddr == vac_pkg::OFS_CAL_CFG) calDis_q <= regWdata[11];
            clkCnt_q <= vcoSerialLatch ? 5'h0 : clkCnt_q + 5'(vcoSerialClock);
        end
    end

    // a search lasts far longer than eight cycles
    sequence s_search_open;
        (vcoCalBit && !freqLoadStrobe) [*8];
    endsequence

    a_read_idle:
    assert property (!$past(regRd) |-> regRdata == 24'h00_0000)
        else $error("read data not idle");
    a_switch_read:
    assert property (regRd && regAddr == vac_pkg::OFS_SW_READ |=> regRdata[7:0] == $past(vcoSwitch))
        else $error("switch readback wrong");
    a_cal_start:
    assert property (wrFrac && !calDis_q |=> s_search_open)
        else $error("search not open");
    a_cal_end:
    assert property ($fell(vcoCalBit) |-> freqLoadStrobe)
        else $error("calibration end without load");
    a_busy_mirror:
    assert property (calBusy == vcoCalBit)
        else $error("busy not calibration bit");
    a_load_cause:
    assert property ($changed(fracLoad) || $changed(intLoad) |-> freqLoadStrobe)
        else $error("load without strobe");
    a_manual_frac:
    assert property (wrFrac && calDis_q |=> freqLoadStrobe && fracLoad == $past(regWdata))
        else $error("manual fraction late");
    a_manual_int:
    assert property (regWr && regAddr == vac_pkg::OFS_INT && calDis_q
        |=> !vcoCalBit && intLoad == $past(regWdata[INT_BITS-1:0]))
        else $error("manual integer late");
    a_manual_switch:
    assert property (wrVco && calDis_q && !calBusy |=> vcoSwitch == $past(regWdata[14:7]))
        else $error("manual switch late");
    a_xfer_length:
    assert property (vcoSerialLatch |-> clkCnt_q + 5'(vcoSerialClock)
        == (calBusy ? vac_pkg::CAL_XFER_CLKS : vac_pkg::MAN_XFER_CLKS))
        else $error("wrong serial clock count");
    a_man_forward:
    assert property (wrVco && calDis_q && !calBusy |-> ##[1:1000] vcoSerialLatch)
        else $error("manual vco write not forwarded");
endmodule

bind vac_autocal vac_autocal_asserts #(.INT_BITS(INT_BITS), .FRAC_BITS(FRAC_BITS)) u_asserts (.*);

// file: tb/vac_vco_model.sv
/*
 * behavioural reference divider and vco: receives the vco serial word and
 * produces phase detector and vco count pulses whose rate follows the switch.
 * assumes the latch pulse follows the last serial clock of a word.
 */
module vac_vco_model #(
    parameter int PD_PERIOD = 72
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic vcoSerialClock,
    input wire logic vcoSerialData,
    input wire logic vcoSerialLatch,
    output logic pdTick,
    output logic vcoTick,
    output logic [7:0] seenSwitch,
    output logic [4:0] lastBits,
    output logic [15:0] xferCount,
    output logic [7:0] clkGap
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [6:0] phase;
    logic [19:0] shiftReg;
    logic [4:0] bitCnt;
    logic [7:0] gapCnt;
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            phase <= 7'h00;
            shiftReg <= 20'h0_0000;
            bitCnt <= 5'h00;
            gapCnt <= 8'h00;
            seenSwitch <= 8'h00;
            lastBits <= 5'h00;
            xferCount <= 16'h0000;
            clkGap <= 8'h00;
        end else begin
            phase <= (phase == 7'(PD_PERIOD - 1)) ? 7'h00 : phase + 7'h01;
            gapCnt <= gapCnt + 8'h01;
            if (vcoSerialClock) begin
                shiftReg <= {shiftReg[18:0], vcoSerialData};
                bitCnt <= bitCnt + 5'h01;
                gapCnt <= 8'h01;
                if (bitCnt != 5'h00) clkGap <= gapCnt;
            end
            if (vcoSerialLatch) begin
                lastBits <= bitCnt;
                bitCnt <= 5'h00;
                xferCount <= xferCount + 16'h0001;
                seenSwitch <= (bitCnt == 5'd20) ? shiftReg[18:11] : shiftReg[14:7];
            end
        end
    end
    // higher switch word means a faster vco; count pulses stay clear of the pd pulse
    assign pdTick = resetn && phase == 7'h00;
    assign vcoTick = phase != 7'h00 && phase <= {1'b0, seenSwitch[7:2]};
endmodule

// file: tb/vac_autocal_bench.sv
/*
 * self-checking bench for vac_autocal: register tasks, calibration runs
 * over several window codes, a restart, and manual vco control.
 * assumes the vco model in vac_vco_model.sv and the bound checker.
 */
module vac_autocal_bench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int N_EXP [8] = '{0, 1, 2, 3, 5, 6, 7, 8};
    localparam int GAP_EXP [4] = '{0, 2, 4, 5};
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic [4:0] regAddr = 5'h00;
    logic [23:0] regWdata = 24'h00_0000;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [23:0] regRdata;
    logic pdTick, vcoTick, freqLoadStrobe, vcoCalBit, calBusy;
    logic vcoSerialClock, vcoSerialData, vcoSerialLatch;
    logic [18:0] intLoad;
    logic [23:0] fracLoad;
    logic [7:0] vcoSwitch, seenSwitch, clkGap;
    logic [4:0] lastBits;
    logic [15:0] xferCount;
    int nErrors = 0;
    int numChecks = 0;
    int nLoads = 0;

    always #25 sys_clk = ~sys_clk;
    always @(posedge sys_clk) if (freqLoadStrobe === 1'b1) nLoads <= nLoads + 1;

    vac_autocal u_vac_autocal (.*);
    vac_vco_model u_vac_vco_model (.*);

    // ----------------------------------------------------------------
    // access and checking tasks
    // ----------------------------------------------------------------
    task automatic stop_test();
        if (nErrors == 0 && numChecks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        numChecks++;
        if (seen !== exp) begin
            nErrors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic guard(input int i, input int bound);
        if (i >= bound) begin
            check("waitBound", 32'h0000_0000, 32'h0000_0001);
            stop_test();
        end
    endtask

    // one idle edge between calls
    task automatic wr(input logic [4:0] a, input logic [23:0] d);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge sys_clk);
        regWr <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic rd(input logic [4:0] a, output logic [23:0] d);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge sys_clk);
        regRd <= 1'b0;
        @(posedge sys_clk);
        d = regRdata;
    endtask

    // reference search against the model's count law
    function automatic logic [7:0] exp_switch(input logic [18:0] nInt,
                                              input logic [23:0] nFrac, input int n);
        logic [63:0] target;
        logic [7:0] sw;
        logic [7:0] trial;
        target = ({21'h0, nInt, nFrac} << n) >> 24;
        sw = 8'h00;
        for (int b = 7; b >= 0; b--) begin
            trial = sw | (8'h01 << b);
            if ((64'(trial >> 2) << n) < target) sw = trial;
        end
        return sw;
    endfunction

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic run_cal(input int code, input logic [23:0] nFrac, input bit restart);
        logic [7:0] sw;
        logic [23:0] d;
        int loads0;
        logic [15:0] x0;
        int i;
        sw = exp_switch(19'd21, nFrac, N_EXP[code]);
        wr(vac_pkg::OFS_CAL_CFG, 24'h00_0040 | 24'(code));
        wr(vac_pkg::OFS_INT, 24'h00_0015);
        loads0 = nLoads;
        if (restart) begin
            wr(vac_pkg::OFS_FRAC, nFrac ^ 24'h80_0000);
            repeat (300) @(posedge sys_clk);
        end
        x0 = xferCount;
        wr(vac_pkg::OFS_FRAC, nFrac);
        @(posedge sys_clk);
        check("calBit", vcoCalBit, 32'h1);
        check("loadHeld", nLoads - loads0, 0);
        i = 0;
        while (vcoCalBit === 1'b1 && i < 30000) begin
            @(posedge sys_clk);
            i++;
        end
        guard(i, 30000);
        check("switch", vcoSwitch, sw);
        rd(vac_pkg::OFS_SW_READ, d);
        check("switchRead", d, {16'h0000, sw});
        check("fracLoad", fracLoad, nFrac);
        check("intLoad", intLoad, 32'h0000_0015);
        check("loads", nLoads - loads0, 1);
        check("calBits", lastBits, 32'd20);
        if (!restart) check("xfers", xferCount - x0, vac_pkg::SEARCH_STEPS + 1);
    endtask

    task automatic man_vco(input int c);
        logic [7:0] sw;
        logic [15:0] x0;
        int i;
        sw = 8'h1A + 8'(c * 16);
        x0 = xferCount;
        wr(vac_pkg::OFS_CAL_CFG, 24'h00_0800 | 24'(c << 13));
        wr(vac_pkg::OFS_VCO, {9'h000, sw, 7'h05});
        @(posedge sys_clk);
        check("manSwitch", vcoSwitch, sw);
        i = 0;
        while (xferCount == x0 && i < 1000) begin
            @(posedge sys_clk);
            i++;
        end
        guard(i, 1000);
        check("vcoWord", seenSwitch, sw);
        check("vcoBits", lastBits, 32'd16);
        check("tickGap", clkGap, 32'(1 << GAP_EXP[c]));
        check("manCalBit", vcoCalBit, 32'h0);
    endtask

    initial begin
        logic [23:0] d;
        repeat (8) @(posedge sys_clk);
        resetn <= 1'b1;
        @(posedge sys_clk);
        check("intReset", intLoad, 32'h0000_0014);
        check("fracReset", fracLoad, 32'h0000_0000);
        rd(vac_pkg::OFS_CAL_CFG, d);
        check("cfgReset", d, vac_pkg::CAL_CFG_RST);
        rd(5'h1F, d);
        check("unmapped", d, 32'h0000_0000);
        for (int c = 0; c < 5; c++) begin
            run_cal(c, 24'h10_0000, c == 2);
        end
        wr(vac_pkg::OFS_CAL_CFG, 24'h00_0800);
        wr(vac_pkg::OFS_FRAC, 24'h12_3456);
        check("manFrac", fracLoad, 32'h0012_3456);
        wr(vac_pkg::OFS_INT, 24'h00_0016);
        check("manInt", intLoad, 32'h0000_0016);
        for (int c = 0; c < 4; c++) begin
            man_vco(c);
        end
        stop_test();
    end
endmodule
